// ### rtl/aux_pin_pkg.sv
// Shared constants, register map and function codes for the auxiliary pin mux
package aux_pin_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int MCLK_KHZ = 100000;
  localparam int LED_PULSE_NS = 40000;
  localparam int LED_PULSE_CYC = (LED_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LED_CNT_W = 12;

  // Output clocks: fast 30 MHz, mid and slow are halves of the one above
  localparam int CLK_FAST_KHZ = 30000;
  localparam int NCO_W = 16;
  localparam int NCO_INC_INT = (CLK_FAST_KHZ * 65536 + MCLK_KHZ / 2) / MCLK_KHZ;
  localparam logic [NCO_W-1:0] NCO_FAST_INC = NCO_INC_INT[NCO_W-1:0];

  // ----------------------------------------------------------------
  // Pins and function codes
  // ----------------------------------------------------------------
  localparam int NUM_PINS = 10;
  localparam int FUNC_W = 4;
  localparam int PD_DEFAULT_PIN = 7;
  localparam logic [NUM_PINS-1:0] CLK_CAPABLE_PINS = 10'h361;
  localparam logic [NUM_PINS-1:0] BITBANG_PINS = 10'h360;

  typedef enum logic [FUNC_W-1:0] {
    F_IN_PU, F_LINE_DRV, F_PWR_EN, F_TX_LED, F_RX_LED, F_TRX_LED, F_SLEEP,
    F_CLK_FAST, F_CLK_MID, F_CLK_SLOW, F_DRIVE1, F_DRIVE0, F_BITBANG, F_IN_PD
  } pin_func_e;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam int ADDR_W = 5;
  localparam logic [ADDR_W-1:0] FUNC_LO_ADDR = 5'h00;
  localparam logic [ADDR_W-1:0] FUNC_HI_ADDR = 5'h04;
  localparam logic [ADDR_W-1:0] CTRL_ADDR = 5'h08;
  localparam logic [ADDR_W-1:0] BITBANG_ADDR = 5'h0c;
  localparam logic [ADDR_W-1:0] STATUS_ADDR = 5'h10;
  localparam int FUNC_LO_PINS = 8;

  // Control fields
  localparam int CTRL_SUSP_PD_BIT = 0;
  localparam int CTRL_WAKE_EN_BIT = 1;
  localparam int CTRL_MODE_LSB = 4;
  localparam int MODE_W = 3;
  localparam int CTRL_BITPER_LSB = 16;
  localparam int BITPER_W = 16;
  localparam logic [MODE_W-1:0] MODE_UART = 3'h0;
  localparam logic [BITPER_W-1:0] BITPER_RESET = 16'h0364;

  // Bit-bang fields
  localparam int BB_DIR_LSB = 16;

  // Status fields
  localparam int ST_SUSPEND_BIT = 16;
  localparam int ST_CONFIG_BIT = 17;
  localparam int ST_WAKE_BIT = 18;
  localparam int ST_LDE_BIT = 19;

endpackage

// ### rtl/activity_led_pulse.sv
// Stretches a one-cycle activity event into a visible low LED pulse
`timescale 1ns/100ps
module activity_led_pulse
  import aux_pin_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic event_pulse,
  output logic led_n
);

  localparam logic [LED_CNT_W-1:0] PULSE_LAST = LED_CNT_W'(LED_PULSE_CYC - 1);

  logic [LED_CNT_W-1:0] cnt_q;
  logic led_n_q;

  // ----------------------------------------------------------------
  // Pulse timer, retriggered by each new event
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
      led_n_q <= 1'b1;
    end else if (ce) begin
      if (event_pulse) begin
        cnt_q <= PULSE_LAST;
        led_n_q <= 1'b0;
      end else if (cnt_q != '0) begin
        cnt_q <= cnt_q - 1'b1;
      end else begin
        led_n_q <= 1'b1;
      end
    end
  end

  assign led_n = led_n_q;

endmodule

// ### rtl/clock_out_gen.sv
// Derives the three pin clock outputs and stops them during suspend
`timescale 1ns/100ps
module clock_out_gen
  import aux_pin_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic suspend,
  output logic clock_out_fast,
  output logic clock_out_mid,
  output logic clock_out_slow
);

  logic [NCO_W-1:0] acc_q;
  logic fast_q;
  logic mid_q;
  logic slow_q;

  // ----------------------------------------------------------------
  // Phase accumulator; average frequency is set by the rounded increment, edges jitter by a cycle
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      acc_q <= '0;
      fast_q <= 1'b0;
      mid_q <= 1'b0;
      slow_q <= 1'b0;
    end else if (ce) begin
      if (suspend) begin
        acc_q <= '0;
        fast_q <= 1'b0;
        mid_q <= 1'b0;
        slow_q <= 1'b0;
      end else begin
        acc_q <= acc_q + NCO_FAST_INC;
        fast_q <= acc_q[NCO_W-1];
        if (acc_q[NCO_W-1] && !fast_q) begin
          mid_q <= !mid_q;
          if (!mid_q) begin
            slow_q <= !slow_q;
          end
        end
      end
    end
  end

  assign clock_out_fast = fast_q;
  assign clock_out_mid = mid_q;
  assign clock_out_slow = slow_q;

endmodule

// ### rtl/aux_pin_function_mux.sv
// Auxiliary pin function mux with Avalon-MM register access
`timescale 1ns/100ps

module aux_pin_function_mux
  import aux_pin_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic usb_configured,
  input wire logic usb_suspend,
  input wire logic tx_request,
  input wire logic tx_stop_done,
  output logic tx_start,
  input wire logic rxd_pin,
  input wire logic ring_indicator_n,
  input wire logic [NUM_PINS-1:0] aux_in,
  output logic [NUM_PINS-1:0] aux_out,
  output logic [NUM_PINS-1:0] aux_oe,
  output logic [NUM_PINS-1:0] aux_pull_up,
  output logic [NUM_PINS-1:0] aux_pull_down,
  output logic uart_in_pull_up,
  output logic uart_in_pull_down,
  output logic [MODE_W-1:0] interface_mode,
  output logic resume_request
);

  typedef enum logic [1:0] {LDE_IDLE, LDE_LEAD, LDE_SEND} lde_state_e;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [NUM_PINS-1:0][FUNC_W-1:0] func_q;
  logic susp_pd_en_q;
  logic wake_en_q;
  logic [MODE_W-1:0] mode_q;
  logic [BITPER_W-1:0] bitper_q;
  logic [NUM_PINS-1:0] bb_data_q;
  logic [NUM_PINS-1:0] bb_dir_q;
  logic wait_q;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic wr_fire;
  logic rd_take;
  logic [NUM_PINS-1:0] aux_meta_q;
  logic [NUM_PINS-1:0] aux_sync_q;
  logic rxd_meta_q;
  logic rxd_sync_q;
  logic rxd_prev_q;
  logic ri_meta_q;
  logic ri_sync_q;
  logic rx_event;
  lde_state_e lde_state_q;
  logic [BITPER_W-1:0] lde_cnt_q;
  logic lde_q;
  logic tx_start_q;
  logic tx_led_n;
  logic rx_led_n;
  logic trx_led_n;
  logic clk_fast;
  logic clk_mid;
  logic clk_slow;
  logic resume_q;
  logic uart_pu_q;
  logic uart_pd_q;
  logic [NUM_PINS-1:0] out_q;
  logic [NUM_PINS-1:0] oe_q;
  logic [NUM_PINS-1:0] pu_q;
  logic [NUM_PINS-1:0] pd_q;

  // Pins may only take functions they physically support
  function automatic logic func_legal(input int pin, input logic [FUNC_W-1:0] code);
    logic ok;
    ok = (code <= F_IN_PD);
    if (code == F_CLK_FAST || code == F_CLK_MID || code == F_CLK_SLOW
        || code == F_DRIVE1) begin
      ok = CLK_CAPABLE_PINS[pin];
    end else if (code == F_BITBANG) begin
      ok = BITBANG_PINS[pin];
    end
    return ok;
  endfunction

  // ----------------------------------------------------------------
  // Avalon-MM slave: one wait cycle, then the access completes
  // ----------------------------------------------------------------
  assign wr_fire = ce && avs_write && !wait_q;
  assign rd_take = ce && avs_read && wait_q;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wait_q <= 1'b1;
    end else if (ce) begin
      if ((avs_read || avs_write) && wait_q) begin
        wait_q <= 1'b0;
      end else begin
        wait_q <= 1'b1;
      end
    end
  end

  always_comb begin
    rdata_d = '0;
    if (avs_address == FUNC_LO_ADDR) begin
      for (int i = 0; i < FUNC_LO_PINS; i++) begin
        rdata_d[i*FUNC_W +: FUNC_W] = func_q[i];
      end
    end else if (avs_address == FUNC_HI_ADDR) begin
      for (int i = FUNC_LO_PINS; i < NUM_PINS; i++) begin
        rdata_d[(i-FUNC_LO_PINS)*FUNC_W +: FUNC_W] = func_q[i];
      end
    end else if (avs_address == CTRL_ADDR) begin
      rdata_d[CTRL_SUSP_PD_BIT] = susp_pd_en_q;
      rdata_d[CTRL_WAKE_EN_BIT] = wake_en_q;
      rdata_d[CTRL_MODE_LSB +: MODE_W] = mode_q;
      rdata_d[CTRL_BITPER_LSB +: BITPER_W] = bitper_q;
    end else if (avs_address == BITBANG_ADDR) begin
      rdata_d[NUM_PINS-1:0] = bb_data_q;
      rdata_d[BB_DIR_LSB +: NUM_PINS] = bb_dir_q;
    end else if (avs_address == STATUS_ADDR) begin
      rdata_d[NUM_PINS-1:0] = aux_sync_q;
      rdata_d[ST_SUSPEND_BIT] = usb_suspend;
      rdata_d[ST_CONFIG_BIT] = usb_configured;
      rdata_d[ST_WAKE_BIT] = resume_q;
      rdata_d[ST_LDE_BIT] = lde_q;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= '0;
    end else if (rd_take) begin
      rdata_q <= rdata_d;
    end
  end

  // ----------------------------------------------------------------
  // Pin function registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_PINS; i++) begin
        func_q[i] <= (i == PD_DEFAULT_PIN) ? F_IN_PD : F_IN_PU;
      end
    end else if (wr_fire) begin
      for (int i = 0; i < NUM_PINS; i++) begin
        if (avs_address == FUNC_LO_ADDR && i < FUNC_LO_PINS) begin
          if (func_legal(i, avs_writedata[i*FUNC_W +: FUNC_W])) begin
            func_q[i] <= avs_writedata[i*FUNC_W +: FUNC_W];
          end
        end else if (avs_address == FUNC_HI_ADDR && i >= FUNC_LO_PINS) begin
          if (func_legal(i, avs_writedata[(i-FUNC_LO_PINS)*FUNC_W +: FUNC_W])) begin
            func_q[i] <= avs_writedata[(i-FUNC_LO_PINS)*FUNC_W +: FUNC_W];
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Control and bit-bang registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      susp_pd_en_q <= 1'b0;
      wake_en_q <= 1'b0;
      mode_q <= MODE_UART;
      bitper_q <= BITPER_RESET;
    end else if (wr_fire && avs_address == CTRL_ADDR) begin
      susp_pd_en_q <= avs_writedata[CTRL_SUSP_PD_BIT];
      wake_en_q <= avs_writedata[CTRL_WAKE_EN_BIT];
      mode_q <= avs_writedata[CTRL_MODE_LSB +: MODE_W];
      bitper_q <= avs_writedata[CTRL_BITPER_LSB +: BITPER_W];
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      bb_data_q <= '0;
      bb_dir_q <= '0;
    end else if (wr_fire && avs_address == BITBANG_ADDR) begin
      bb_data_q <= avs_writedata[NUM_PINS-1:0];
      bb_dir_q <= avs_writedata[BB_DIR_LSB +: NUM_PINS];
    end
  end

  // ----------------------------------------------------------------
  // Pin input synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      aux_meta_q <= '0;
      aux_sync_q <= '0;
      rxd_meta_q <= 1'b1;
      rxd_sync_q <= 1'b1;
      rxd_prev_q <= 1'b1;
      ri_meta_q <= 1'b1;
      ri_sync_q <= 1'b1;
    end else if (ce) begin
      aux_meta_q <= aux_in;
      aux_sync_q <= aux_meta_q;
      rxd_meta_q <= rxd_pin;
      rxd_sync_q <= rxd_meta_q;
      rxd_prev_q <= rxd_sync_q;
      ri_meta_q <= ring_indicator_n;
      ri_sync_q <= ri_meta_q;
    end
  end

  // Start-bit edge on the receive line marks receive activity
  assign rx_event = rxd_prev_q && !rxd_sync_q;

  // ----------------------------------------------------------------
  // Line driver enable sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      lde_state_q <= LDE_IDLE;
      lde_cnt_q <= '0;
      lde_q <= 1'b0;
      tx_start_q <= 1'b0;
    end else if (ce) begin
      tx_start_q <= 1'b0;
      case (lde_state_q)
        LDE_IDLE: begin
          if (tx_request) begin
            lde_q <= 1'b1;
            lde_cnt_q <= (bitper_q == '0) ? '0 : bitper_q - 1'b1;
            lde_state_q <= LDE_LEAD;
          end
        end
        LDE_LEAD: begin
          if (lde_cnt_q == '0) begin
            tx_start_q <= 1'b1;
            lde_state_q <= LDE_SEND;
          end else begin
            lde_cnt_q <= lde_cnt_q - 1'b1;
          end
        end
        LDE_SEND: begin
          if (tx_stop_done) begin
            lde_q <= 1'b0;
            lde_state_q <= LDE_IDLE;
          end
        end
        default: begin
          lde_q <= 1'b0;
          lde_state_q <= LDE_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Activity LEDs and clock outputs
  // ----------------------------------------------------------------
  activity_led_pulse u_tx_led (
    .mclk(mclk),
    .rst_n(rst_n),
    .ce(ce),
    .event_pulse(tx_start_q),
    .led_n(tx_led_n)
  );

  activity_led_pulse u_rx_led (
    .mclk(mclk),
    .rst_n(rst_n),
    .ce(ce),
    .event_pulse(rx_event),
    .led_n(rx_led_n)
  );

  activity_led_pulse u_trx_led (
    .mclk(mclk),
    .rst_n(rst_n),
    .ce(ce),
    .event_pulse(tx_start_q || rx_event),
    .led_n(trx_led_n)
  );

  clock_out_gen u_clk (
    .mclk(mclk),
    .rst_n(rst_n),
    .ce(ce),
    .suspend(usb_suspend),
    .clock_out_fast(clk_fast),
    .clock_out_mid(clk_mid),
    .clock_out_slow(clk_slow)
  );

  // ----------------------------------------------------------------
  // Suspend pull control and wake request
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      uart_pu_q <= 1'b1;
      uart_pd_q <= 1'b0;
      resume_q <= 1'b0;
    end else if (ce) begin
      uart_pd_q <= susp_pd_en_q && usb_suspend;
      uart_pu_q <= !(susp_pd_en_q && usb_suspend);
      resume_q <= wake_en_q && usb_suspend && !ri_sync_q;
    end
  end

  // ----------------------------------------------------------------
  // Per-pin output mux
  // ----------------------------------------------------------------
  for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
    logic out_d;
    logic oe_d;
    logic pu_d;
    logic pd_d;

    always_comb begin
      out_d = 1'b0;
      oe_d = 1'b1;
      pu_d = 1'b0;
      pd_d = 1'b0;
      case (pin_func_e'(func_q[i]))
        F_LINE_DRV: out_d = lde_q;
        F_PWR_EN: out_d = !(usb_configured && !usb_suspend);
        F_TX_LED: out_d = tx_led_n;
        F_RX_LED: out_d = rx_led_n;
        F_TRX_LED: out_d = trx_led_n;
        F_SLEEP: out_d = !usb_suspend;
        F_CLK_FAST: out_d = clk_fast;
        F_CLK_MID: out_d = clk_mid;
        F_CLK_SLOW: out_d = clk_slow;
        F_DRIVE1: out_d = 1'b1;
        F_DRIVE0: out_d = 1'b0;
        F_BITBANG: begin
          out_d = bb_data_q[i];
          oe_d = bb_dir_q[i];
          pu_d = !bb_dir_q[i];
        end
        F_IN_PD: begin
          oe_d = 1'b0;
          pd_d = 1'b1;
        end
        default: begin
          oe_d = 1'b0;
          pu_d = 1'b1;
        end
      endcase
    end

    always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
        out_q[i] <= 1'b0;
        oe_q[i] <= 1'b0;
        pu_q[i] <= (i != PD_DEFAULT_PIN);
        pd_q[i] <= (i == PD_DEFAULT_PIN);
      end else if (ce) begin
        out_q[i] <= out_d;
        oe_q[i] <= oe_d;
        pu_q[i] <= pu_d;
        pd_q[i] <= pd_d;
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign avs_readdata = rdata_q;
  assign avs_waitrequest = wait_q;
  assign tx_start = tx_start_q;
  assign aux_out = out_q;
  assign aux_oe = oe_q;
  assign aux_pull_up = pu_q;
  assign aux_pull_down = pd_q;
  assign uart_in_pull_up = uart_pu_q;
  assign uart_in_pull_down = uart_pd_q;
  assign interface_mode = mode_q;
  assign resume_request = resume_q;

endmodule

// ### verif/aux_far_side_model.sv
// Far-side glue model: pin levels seen by external parts and the serial engine
`timescale 1ns/100ps
module aux_far_side_model
  import aux_pin_pkg::*;
#(
  parameter int FRAME_CYC = 100
)(
  input wire logic mclk,
  input wire logic [NUM_PINS-1:0] aux_out,
  input wire logic [NUM_PINS-1:0] aux_oe,
  input wire logic [NUM_PINS-1:0] aux_pull_up,
  input wire logic [NUM_PINS-1:0] aux_pull_down,
  input wire logic tx_start,
  output logic tx_stop_done,
  output logic [NUM_PINS-1:0] aux_in
);
  logic float_q = 1'b0;
  int cnt = 0;
  // ----------------------------------------------------------------
  // Pin levels: undriven and unpulled pins wander every cycle
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    float_q <= ~float_q;
  end
  always_comb begin
    for (int i = 0; i < NUM_PINS; i++) begin
      aux_in[i] = aux_oe[i] ? aux_out[i] : aux_pull_up[i] ? 1'b1 :
                  aux_pull_down[i] ? 1'b0 : float_q;
    end
  end
  // ----------------------------------------------------------------
  // Serial engine: sends a frame after each start grant
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    tx_stop_done <= (cnt == 1);
    if (tx_start) begin
      cnt <= FRAME_CYC;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
    end
  end
endmodule

// ### verif/aux_pin_function_mux_chk.sv
// Concurrent checks on the auxiliary pin mux ports
`timescale 1ns/100ps
module aux_pin_function_mux_chk
  import aux_pin_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic avs_waitrequest,
  input wire logic usb_configured,
  input wire logic usb_suspend,
  input wire logic tx_start,
  input wire logic ring_indicator_n,
  input wire logic [NUM_PINS-1:0] aux_out,
  input wire logic [NUM_PINS-1:0] aux_oe,
  input wire logic [NUM_PINS-1:0] aux_pull_up,
  input wire logic [NUM_PINS-1:0] aux_pull_down,
  input wire logic [MODE_W-1:0] interface_mode,
  input wire logic resume_request
);
  logic [3:0] f0_q;
  logic [3:0] f1_q;
  logic [3:0] c0;
  logic [3:0] c1;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // ----------------------------------------------------------------
  // Codes accepted for pins 0 and 1
  // ----------------------------------------------------------------
  assign c0 = avs_writedata[3:0];
  assign c1 = avs_writedata[7:4];
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      f0_q <= 4'h0;
      f1_q <= 4'h0;
    end else if (avs_write && !avs_waitrequest && avs_address == FUNC_LO_ADDR) begin
      if (c0 < 4'he) f0_q <= c0;
      if (c1 < 4'h7 || c1 == 4'hb || c1 == 4'hd) f1_q <= c1;
    end
  end
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  a_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus request not answered next cycle");
  a_bus_single: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("bus answer held too long");
  a_reset_pulls: assert property ($rose(rst_n) |->
    aux_oe == 10'h000 && aux_pull_up == 10'h37f && aux_pull_down == 10'h080)
    else $error("pin defaults wrong after reset");
  a_reset_mode: assert property ($rose(rst_n) |-> interface_mode == MODE_UART)
    else $error("interface mode not serial after reset");
  a_line_drv_lead: assert property (f1_q == F_LINE_DRV && tx_start |->
    aux_oe[1] && aux_out[1] && $past(aux_out[1], 2))
    else $error("line driver not enabled ahead of start bit");
  a_tx_led: assert property (f0_q == F_TX_LED && tx_start |-> ##[1:3] !aux_out[0])
    else $error("transmit led did not pulse");
  a_power_pin: assert property (f0_q == F_PWR_EN && $past(f0_q, 2) == F_PWR_EN |->
    aux_out[0] == !($past(usb_configured) && !$past(usb_suspend)))
    else $error("power pin level wrong");
  a_sleep_pin: assert property (f1_q == F_SLEEP && $past(f1_q, 2) == F_SLEEP |->
    aux_out[1] == !$past(usb_suspend))
    else $error("suspend pin level wrong");
  a_clocks_stop: assert property (
    (f0_q inside {F_CLK_FAST, F_CLK_MID, F_CLK_SLOW} && usb_suspend) [*3] |-> !aux_out[0])
    else $error("clock pin runs in suspend");
  a_drive_low: assert property (f0_q == F_DRIVE0 && $past(f0_q, 2) == F_DRIVE0 |->
    aux_oe[0] && !aux_out[0])
    else $error("drive low pin not driving low");
  a_resume_cause: assert property ($rose(resume_request) |->
    usb_suspend && !$past(ring_indicator_n, 3))
    else $error("resume without suspend and ring");
  a_resume_idle: assert property (ring_indicator_n [*5] |-> !resume_request)
    else $error("resume with ring input high");
endmodule
bind aux_pin_function_mux aux_pin_function_mux_chk u_chk (.mclk, .rst_n, .avs_address,
  .avs_read, .avs_write, .avs_writedata, .avs_waitrequest, .usb_configured, .usb_suspend,
  .tx_start, .ring_indicator_n, .aux_out, .aux_oe, .aux_pull_up, .aux_pull_down,
  .interface_mode, .resume_request);

// ### verif/aux_pin_function_mux_tb.sv
// Register-driven testbench for the auxiliary pin mux
`timescale 1ns/100ps
module aux_pin_function_mux_tb
  import aux_pin_pkg::*;
;
  localparam int BIT_N = 20;
  logic mclk, rst_n, avs_read, avs_write, avs_waitrequest, usb_configured, usb_suspend;
  logic tx_request, tx_stop_done, tx_start, rxd_pin, ring_indicator_n, resume_request;
  logic uart_in_pull_up, uart_in_pull_down, ce;
  logic [ADDR_W-1:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [NUM_PINS-1:0] aux_in, aux_out, aux_oe, aux_pull_up, aux_pull_down;
  logic [MODE_W-1:0] interface_mode;
  int mismatches = 0;
  int comparisons = 0;
  int n;
  int e[3];
  aux_pin_function_mux DUT (.mclk, .rst_n, .ce, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_readdata, .avs_waitrequest, .usb_configured, .usb_suspend,
    .tx_request, .tx_stop_done, .tx_start, .rxd_pin, .ring_indicator_n, .aux_in, .aux_out,
    .aux_oe, .aux_pull_up, .aux_pull_down, .uart_in_pull_up, .uart_in_pull_down,
    .interface_mode, .resume_request);
  aux_far_side_model far (.mclk, .aux_out, .aux_oe, .aux_pull_up, .aux_pull_down,
    .tx_start, .tx_stop_done, .aux_in);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do begin
      @(posedge mclk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(q, exp);
  endtask
  task automatic edges(input int cyc);
    logic [2:0] p;
    p = {aux_out[6], aux_out[5], aux_out[0]};
    e = '{0, 0, 0};
    repeat (cyc) begin
      @(posedge mclk);
      if (aux_out[0] && !p[0]) e[0]++;
      if (aux_out[5] && !p[1]) e[1]++;
      if (aux_out[6] && !p[2]) e[2]++;
      p = {aux_out[6], aux_out[5], aux_out[0]};
    end
  endtask
  task automatic give_verdict;
    $display("Counts: %0d comparisons, %0d mismatches", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Clock, watchdog and tests
  // ----------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  initial begin
    #300000;
    mismatches++;
    $display("CHECK FAILED %0t watchdog expired", $time);
    give_verdict;
  end
  initial begin
    {rst_n, avs_read, avs_write, usb_configured, usb_suspend, tx_request} = 6'h0;
    ce = 1'b1;
    {rxd_pin, ring_indicator_n, avs_address, avs_writedata} = '1;
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    chk({aux_oe, aux_pull_up, aux_pull_down}, {10'h000, 10'h37f, 10'h080});
    chk({interface_mode, uart_in_pull_up, uart_in_pull_down}, {MODE_UART, 2'b10});
    rd(CTRL_ADDR, {BITPER_RESET, 16'h0});
    rd(FUNC_LO_ADDR, 32'hd0000000);
    $display("Test reset defaults done");
    for (int c = 7; c <= 10; c++) begin
      bus(1'b1, FUNC_LO_ADDR, (c << 28) | (c << 4) | c);
      rd(FUNC_LO_ADDR, 32'hd0000000 | c);
    end
    repeat (2) @(posedge mclk);
    chk({aux_oe[0], aux_out[0]}, 2'b11);
    rd(5'h14, 32'h0);
    $display("Test pin refusal done");
    bus(1'b1, FUNC_LO_ADDR, 32'hd0c0000b);
    bus(1'b1, BITBANG_ADDR, 32'h00000020);
    repeat (5) @(posedge mclk);
    chk({aux_oe[5], aux_pull_up[5], aux_oe[0], aux_out[0]}, 4'b0110);
    rd(STATUS_ADDR, 32'h0000037e);
    bus(1'b1, BITBANG_ADDR, 32'h00200020);
    repeat (2) @(posedge mclk);
    chk({aux_oe[5], aux_out[5]}, 2'b11);
    $display("Test fixed levels done");
    bus(1'b1, CTRL_ADDR, (BIT_N << 16) | 3);
    bus(1'b1, FUNC_LO_ADDR, 32'hd0005413);
    tx_request <= 1'b1;
    @(posedge mclk);
    tx_request <= 1'b0;
    for (n = 0; aux_out[1] !== 1'b1 && n < 50; n++) @(posedge mclk);
    chk(n, 2);
    for (n = 0; tx_start !== 1'b1 && n < 200; n++) @(posedge mclk);
    chk(n >= BIT_N - 1 && n <= BIT_N + 1, 1);
    repeat (4) @(posedge mclk);
    chk({aux_out[3:0]}, 4'b0110);
    for (n = 0; tx_stop_done !== 1'b1 && n < 200; n++) @(posedge mclk);
    chk(n < 200, 1);
    chk(aux_out[1], 1);
    repeat (3) @(posedge mclk);
    chk(aux_out[1], 0);
    rxd_pin <= 1'b0;
    repeat (8) @(posedge mclk);
    chk({aux_out[3], aux_out[2]}, 2'b00);
    rxd_pin <= 1'b1;
    repeat (4100) @(posedge mclk);
    chk({aux_out[3], aux_out[2], aux_out[0]}, 3'b111);
    $display("Test frame and leds done");
    bus(1'b1, FUNC_LO_ADDR, 32'hd0000062);
    usb_configured <= 1'b1;
    repeat (3) @(posedge mclk);
    chk(aux_out[1:0], 2'b10);
    usb_suspend <= 1'b1;
    repeat (4) @(posedge mclk);
    chk(aux_out[1:0], 2'b01);
    chk({uart_in_pull_up, uart_in_pull_down, resume_request}, 3'b010);
    ring_indicator_n <= 1'b0;
    repeat (6) @(posedge mclk);
    chk(resume_request, 1);
    ring_indicator_n <= 1'b1;
    usb_suspend <= 1'b0;
    repeat (6) @(posedge mclk);
    chk({uart_in_pull_up, uart_in_pull_down, resume_request}, 3'b100);
    $display("Test suspend and wake done");
    bus(1'b1, FUNC_LO_ADDR, 32'hd9800007);
    edges(400);
    chk({e[0] inside {[118:122]}, e[1] inside {[58:62]}, e[2] inside {[28:32]}}, 3'b111);
    usb_suspend <= 1'b1;
    repeat (3) @(posedge mclk);
    edges(100);
    chk(e[0] + e[1] + e[2], 0);
    ce <= 1'b0;
    usb_suspend <= 1'b0;
    edges(20);
    chk(e[0] + e[1] + e[2] + aux_out[0], 0);
    ce <= 1'b1;
    $display("Test clock outputs done");
    give_verdict;
  end
endmodule
